// file: phy_led_xover_map.vh
`ifndef PHY_LED_XOVER_MAP_VH
`define PHY_LED_XOVER_MAP_VH

// ==========================================================================
// Register byte offsets on the bus
`define LED_SOURCE_SELECT_OFS 8'h00
`define PAIR_CROSSOVER_CONTROL_OFS 8'h04
`define LINE_STATUS_OFS 8'h08

// ==========================================================================
// Indicator select register fields and reset values
`define SECOND_SEL_HI 7
`define SECOND_SEL_LO 4
`define FIRST_SEL_HI 3
`define FIRST_SEL_LO 0
`define SECOND_SEL_RST 4'h1
`define FIRST_SEL_RST 4'h0
`define LED_SPARE_RST 8'h00

// ==========================================================================
// Indicator source codes
`define IND_LINK 4'h0
`define IND_ANY_ACT 4'h1
`define IND_TX_ACT 4'h2
`define IND_RX_ACT 4'h3
`define IND_COLL 4'h4
`define IND_SPEED_100 4'h5
`define IND_SPEED_10 4'h6
`define IND_FULL_DPLX 4'h7
`define IND_LINK_BLINK 4'h8

// ==========================================================================
// Pair crossover control fields and reset values
`define PD_ASSIST_BIT 7
`define AUTO_PAIR_SWITCH_ENABLE_BIT 6
`define XOVER_BIT 5
`define SW_DONE_BIT 4
`define SEED_HI 3
`define SEED_LO 0
`define PD_ASSIST_RST 1'b1
`define AUTO_PAIR_SWITCH_ENABLE_RST 1'b1
`define XOVER_RST 1'b0
`define SEED_RST 4'h0
`define SEED_INTERNAL 4'h5

// ==========================================================================
// Timing: clock rate, attempt slot and blink half period
`define CLK_KHZ 200000
`define SLOT_TIME_MS 62
`define BLINK_HALF_MS 40
`define SLOT_CYCLES (`SLOT_TIME_MS * `CLK_KHZ)
`define BLINK_CYCLES (`BLINK_HALF_MS * `CLK_KHZ)

`endif

// file: indicator_select.v
`timescale 1ns/10ps
`include "phy_led_xover_map.vh"

module indicator_select
(
  // Clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // Source code and line state
  input wire [3:0] sel_i,
  input wire link_i,
  input wire any_act_i,
  input wire tx_act_i,
  input wire rx_act_i,
  input wire coll_i,
  input wire speed_100_i,
  input wire full_dplx_i,
  input wire blink_off_i,
  // Indicator drive
  output wire led_o
);

  reg led_reg;
  reg led_next;

  // ==========================================================================
  // Source selection
  always @*
  begin
    case (sel_i)
      `IND_LINK: led_next = link_i;
      `IND_ANY_ACT: led_next = any_act_i;
      `IND_TX_ACT: led_next = tx_act_i;
      `IND_RX_ACT: led_next = rx_act_i;
      `IND_COLL: led_next = coll_i;
      `IND_SPEED_100: led_next = link_i & speed_100_i;
      `IND_SPEED_10: led_next = link_i & ~speed_100_i;
      `IND_FULL_DPLX: led_next = link_i & full_dplx_i;
      `IND_LINK_BLINK: led_next = link_i & ~blink_off_i;
      default: led_next = 1'b0;
    endcase
  end

  // Registered drive
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      led_reg <= 1'b0;
    else
      led_reg <= led_next;
  end

  assign led_o = led_reg;

endmodule

// file: phy_led_select_crossover_ctrl.v
// Notes on behaviour
// - Second selector bits 7:4, resets to 0001.
// - First selector bits 3:0, resets to 0000.
// - Codes 1-4: any, tx, rx activity, collision.
// - Codes 5-7: 100 Mb/s, 10 Mb/s, full duplex.
// - Code 8: link on, blink on activity.
// - Enable bit 6 resets 1, enables auto switching.
// - Pair state bit 5: 1 crossover, resets 0.
// - Pair state writable only while switching disabled.
// - Done bit 4: set when sequence finished.
// - Seed bits 3:0 steer attempts 9,8,5,4.
// - Seed 0000 means internal seed 0101.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "phy_led_xover_map.vh"

module phy_led_select_crossover_ctrl
#(
  parameter SLOT_CYCLES = `SLOT_CYCLES,
  parameter BLINK_CYCLES = `BLINK_CYCLES
)
(
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Line state from the transceiver
  input wire link_good_i,
  input wire rx_active_i,
  input wire tx_active_i,
  input wire collision_i,
  input wire speed_100_i,
  input wire full_duplex_i,
  input wire local_aneg_en_i,
  input wire partner_aneg_seen_i,
  // Indicators and pair control
  output wire [1:0] led_o,
  output wire pair_crossover_o,
  output wire pair_switch_done_o
);

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_TRY = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // ==========================================================================
  // Reset release through two flip-flops
  reg rst_meta_reg;
  reg rst_n_reg;

  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Register storage
  reg [7:0] led_spare_reg;
  reg [3:0] second_sel_reg;
  reg [3:0] first_sel_reg;
  reg pd_assist_reg;
  reg auto_pair_switch_enable_reg;
  reg xover_reg;
  reg sw_done_reg;
  reg [3:0] seed_reg;
  reg [1:0] state_reg;
  reg [3:0] attempt_reg;
  reg [7:0] lfsr_reg;
  reg [31:0] slot_cnt_reg;
  reg ack_reg;
  reg [31:0] rdata_reg;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_req = bus_req & wb_we_i;
  wire led_hit = (wb_adr_i == `LED_SOURCE_SELECT_OFS);
  wire pxc_hit = (wb_adr_i == `PAIR_CROSSOVER_CONTROL_OFS);
  wire stat_hit = (wb_adr_i == `LINE_STATUS_OFS);
  wire wr_led_lo = wr_req & led_hit & wb_sel_i[0];
  wire wr_led_hi = wr_req & led_hit & wb_sel_i[1];
  wire wr_pxc = wr_req & pxc_hit & wb_sel_i[0];

  // ==========================================================================
  // Indicator select register
  always @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      second_sel_reg <= `SECOND_SEL_RST;
      first_sel_reg <= `FIRST_SEL_RST;
      led_spare_reg <= `LED_SPARE_RST;
    end
    else
    begin
      if (wr_led_lo)
      begin
        second_sel_reg <= wb_dat_i[`SECOND_SEL_HI:`SECOND_SEL_LO];
        first_sel_reg <= wb_dat_i[`FIRST_SEL_HI:`FIRST_SEL_LO];
      end
      if (wr_led_hi)
        led_spare_reg <= wb_dat_i[15:8];
    end
  end

  // ==========================================================================
  // Pair crossover control bits written by software
  always @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pd_assist_reg <= `PD_ASSIST_RST;
      auto_pair_switch_enable_reg <= `AUTO_PAIR_SWITCH_ENABLE_RST;
      seed_reg <= `SEED_RST;
    end
    else if (wr_pxc)
    begin
      pd_assist_reg <= wb_dat_i[`PD_ASSIST_BIT];
      auto_pair_switch_enable_reg <= wb_dat_i[`AUTO_PAIR_SWITCH_ENABLE_BIT];
      seed_reg <= wb_dat_i[`SEED_HI:`SEED_LO];
    end
  end

  // ==========================================================================
  // Switching sequence controls

  // Seed in use; zero selects the built-in pattern
  wire [3:0] eff_seed = (seed_reg == 4'h0) ? `SEED_INTERNAL : seed_reg;

  // Parallel detect case: local negotiation off while partner negotiates
  wire pd_case = ~local_aneg_en_i & partner_aneg_seen_i;
  wire sw_run = auto_pair_switch_enable_reg & (~pd_case | pd_assist_reg);

  // Slot end marks one failed attempt
  wire slot_end = (slot_cnt_reg == SLOT_CYCLES - 1);

  // Choice for the next attempt: seed bits on attempts 9, 8, 5 and 4
  reg next_choice;
  wire [3:0] next_attempt = attempt_reg + 4'h1;

  always @*
  begin
    case (next_attempt)
      4'h9: next_choice = eff_seed[3];
      4'h8: next_choice = eff_seed[2];
      4'h5: next_choice = eff_seed[1];
      4'h4: next_choice = eff_seed[0];
      default: next_choice = lfsr_reg[7];
    endcase
  end

  // Sequencer, attempt slot and pair assignment
  always @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= ST_IDLE;
      attempt_reg <= 4'h0;
      lfsr_reg <= 8'h00;
      slot_cnt_reg <= 32'h0;
      xover_reg <= `XOVER_RST;
      sw_done_reg <= 1'b0;
    end
    else if (!sw_run)
    begin
      // Switching off: software owns the pair state
      state_reg <= ST_IDLE;
      sw_done_reg <= 1'b0;
      slot_cnt_reg <= 32'h0;
      if (wr_pxc && !wb_dat_i[`AUTO_PAIR_SWITCH_ENABLE_BIT])
        xover_reg <= wb_dat_i[`XOVER_BIT];
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // Start a fresh sequence at attempt 0
          state_reg <= ST_TRY;
          attempt_reg <= 4'h0;
          lfsr_reg <= {eff_seed, ~eff_seed};
          slot_cnt_reg <= 32'h0;
          sw_done_reg <= 1'b0;
        end
        ST_TRY:
        begin
          if (link_good_i)
          begin
            state_reg <= ST_DONE;
            sw_done_reg <= 1'b1;
          end
          else if (slot_end)
          begin
            slot_cnt_reg <= 32'h0;
            attempt_reg <= next_attempt;
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            xover_reg <= next_choice;
          end
          else
            slot_cnt_reg <= slot_cnt_reg + 32'h1;
        end
        ST_DONE:
        begin
          // Link lost: search again from the current pair state
          if (!link_good_i)
          begin
            state_reg <= ST_TRY;
            sw_done_reg <= 1'b0;
            slot_cnt_reg <= 32'h0;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          sw_done_reg <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Activity stretching so that short frames give a visible blink
  wire [3:0] act_raw = {collision_i, rx_active_i, tx_active_i, rx_active_i | tx_active_i};
  wire [3:0] act_str;
  reg [31:0] blink_cnt_reg;
  reg blink_phase_reg;

  // Free running half-period timer for the blink phase
  always @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      blink_cnt_reg <= 32'h0;
      blink_phase_reg <= 1'b0;
    end
    else if (blink_cnt_reg == BLINK_CYCLES - 1)
    begin
      blink_cnt_reg <= 32'h0;
      blink_phase_reg <= ~blink_phase_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
  end

  // One stretcher per activity source: held on for one blink half period
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_stretch
      reg [31:0] hold_cnt_reg;
      always @(posedge core_clk_i or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          hold_cnt_reg <= 32'h0;
        else if (act_raw[gi])
          hold_cnt_reg <= BLINK_CYCLES;
        else if (hold_cnt_reg != 32'h0)
          hold_cnt_reg <= hold_cnt_reg - 32'h1;
      end
      assign act_str[gi] = act_raw[gi] | (hold_cnt_reg != 32'h0);
    end
  endgenerate

  // Link-with-blink: dark during alternate half periods while active
  wire blink_off = act_str[0] & blink_phase_reg;

  // ==========================================================================
  // Indicator drivers, one per selector field
  wire [3:0] sel_vec [0:1];
  assign sel_vec[0] = first_sel_reg;
  assign sel_vec[1] = second_sel_reg;

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_led
      indicator_select u_sel
      (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_reg),
        .sel_i(sel_vec[gi]),
        .link_i(link_good_i),
        .any_act_i(act_str[0]),
        .tx_act_i(act_str[1]),
        .rx_act_i(act_str[2]),
        .coll_i(act_str[3]),
        .speed_100_i(speed_100_i),
        .full_dplx_i(full_duplex_i),
        .blink_off_i(blink_off),
        .led_o(led_o[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Read data and acknowledge
  reg [31:0] rdata_next;

  always @*
  begin
    rdata_next = 32'h0;
    if (led_hit)
      rdata_next = {16'h0, led_spare_reg, second_sel_reg, first_sel_reg};
    else if (pxc_hit)
      rdata_next = {24'h0, pd_assist_reg, auto_pair_switch_enable_reg, xover_reg, sw_done_reg, seed_reg};
    else if (stat_hit)
      rdata_next = {20'h0, attempt_reg, 2'b00, state_reg, act_str};
  end

  // Single-wait answer; unmapped addresses answer with zero
  always @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_i)
        rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign pair_crossover_o = xover_reg;
  assign pair_switch_done_o = sw_done_reg;

endmodule

// file: phy_led_select_crossover_ctrl_props.sv
`timescale 1ns/10ps
// ==========================================
// Port-level checks of the indicator and pair control block
module phy_led_select_crossover_ctrl_props
#(parameter SLOT_CYCLES = 20, parameter BLINK_CYCLES = 8)
(
  // Clock, reset and bus
  input wire core_clk_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Line state
  input wire link_good_i,
  input wire rx_active_i,
  input wire tx_active_i,
  input wire collision_i,
  input wire speed_100_i,
  input wire full_duplex_i,
  input wire local_aneg_en_i,
  input wire partner_aneg_seen_i,
  // Outputs watched
  input wire [1:0] led_o,
  input wire pair_crossover_o,
  input wire pair_switch_done_o
);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_lo = take && wb_we_i && wb_sel_i[0];
  wire sel_wr = wr_lo && wb_adr_i == 8'h00;
  wire ctl_wr = wr_lo && wb_adr_i == 8'h04;
  reg [7:0] sel_reg;
  reg auto_reg;
  reg force_reg;
  reg [1:0] age_reg;
  // Shadow of written fields; age counts quiet cycles since a selector write
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sel_reg <= 8'h10;
      auto_reg <= 1'b1;
      force_reg <= 1'b0;
      age_reg <= 2'h0;
    end
    else
    begin
      if (sel_wr)
        sel_reg <= wb_dat_i[7:0];
      if (ctl_wr)
        auto_reg <= wb_dat_i[6];
      if (ctl_wr)
        force_reg <= wb_dat_i[5];
      age_reg <= sel_wr ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
    end
  end
  wire quiet = age_reg == 2'h3;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ack_reply_a: assert property (take |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  link_led_a: assert property (quiet && sel_reg[3:0] == 4'h0 |->
    led_o[0] == $past(link_good_i))
    else $error("link led wrong");
  tx_led_a: assert property (quiet && sel_reg[7:4] == 4'h2 && $past(tx_active_i) |->
    led_o[1])
    else $error("tx led dark");
  speed_led_a: assert property (quiet && sel_reg[7:4] == 4'h5 |->
    led_o[1] == $past(link_good_i && speed_100_i))
    else $error("speed led wrong");
  undef_led_a: assert property (quiet && sel_reg[3:0] > 4'h8 |-> !led_o[0])
    else $error("undefined code lit");
  done_off_a: assert property (!auto_reg && $past(!auto_reg) |-> !pair_switch_done_o)
    else $error("done while disabled");
  // Pair state is forced only by a write made while switching is already off
  force_pair_a: assert property (ctl_wr && !wb_dat_i[6] && !auto_reg |=>
    ##[0:1] pair_crossover_o == force_reg)
    else $error("forced pair not taken");
  done_link_a: assert property ($rose(pair_switch_done_o) |->
    $past(link_good_i) || $past(link_good_i, 2))
    else $error("done without link");
endmodule

bind phy_led_select_crossover_ctrl phy_led_select_crossover_ctrl_props
  #(.SLOT_CYCLES(SLOT_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) props_u
(
  .core_clk_i(core_clk_i),
  .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .link_good_i(link_good_i),
  .rx_active_i(rx_active_i),
  .tx_active_i(tx_active_i),
  .collision_i(collision_i),
  .speed_100_i(speed_100_i),
  .full_duplex_i(full_duplex_i),
  .local_aneg_en_i(local_aneg_en_i),
  .partner_aneg_seen_i(partner_aneg_seen_i),
  .led_o(led_o),
  .pair_crossover_o(pair_crossover_o),
  .pair_switch_done_o(pair_switch_done_o)
);

// file: link_partner_model.sv
`timescale 1ns/10ps
// ==========================================
// Far end of the cable: link comes up once the pairs line up for 4 cycles
module link_partner_model
(
  // Clock and cable state
  input wire core_clk_i,
  input wire plugged_i,
  input wire want_x_i,
  input wire pair_x_i,
  // Link seen by the receiver
  output reg link_o
);
  integer age = 0;
  initial link_o = 1'b0;
  // Pairs must match and stay matched before link is reported
  always @(posedge core_clk_i)
  begin
    age <= (plugged_i && pair_x_i == want_x_i) ? age + 1 : 0;
    link_o <= age >= 4;
  end
endmodule

// file: phy_led_select_crossover_ctrl_tb_top.sv
`timescale 1ns/10ps
// ==========================================
// Self-checking bench
module phy_led_select_crossover_ctrl_tb_top;
  localparam BL = 8;
  reg core_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sl = 4'hF;
  reg [31:0] wd = 32'h0;
  reg rx = 0, tx = 0, co = 0, sp = 0, fd = 0, la = 1, pa = 0, plug = 0, want = 0;
  wire [31:0] rdat;
  wire ack, link, px, done;
  wire [1:0] led;
  integer bad_count = 0, compares = 0, i, k, n;
  reg [31:0] rd, rn;
  reg [3:0] sd;
  phy_led_select_crossover_ctrl #(.SLOT_CYCLES(20), .BLINK_CYCLES(BL)) dut_u
  (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sl), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link_good_i(link), .rx_active_i(rx), .tx_active_i(tx),
    .collision_i(co), .speed_100_i(sp), .full_duplex_i(fd), .local_aneg_en_i(la),
    .partner_aneg_seen_i(pa), .led_o(led), .pair_crossover_o(px), .pair_switch_done_o(done)
  );
  link_partner_model partner_u
  (
    .core_clk_i(core_clk_i), .plugged_i(plug), .want_x_i(want), .pair_x_i(px), .link_o(link)
  );
  // Clock
  initial forever #2.5 core_clk_i = ~core_clk_i;
  // Compare and count
  task check(input [31:0] seen, input [31:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  // One classic bus cycle; read data lands in rd
  task bus(input w, input [7:0] a, input [31:0] d);
  begin
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge core_clk_i);
    while (ack !== 1'b1)
      @(posedge core_clk_i);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge core_clk_i);
  end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge core_clk_i);
  endtask
  // Reference indicator model
  function exp_led(input [3:0] c);
    case (c)
      4'h0: exp_led = link;
      4'h1: exp_led = rx | tx;
      4'h2: exp_led = tx;
      4'h3: exp_led = rx;
      4'h4: exp_led = co;
      4'h5: exp_led = link & sp;
      4'h6: exp_led = link & !sp;
      4'h7: exp_led = link & fd;
      4'h8: exp_led = link;
      default: exp_led = 1'b0;
    endcase
  endfunction
  task test_done;
  begin
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    tick(20000);
    bad_count = bad_count + 1;
    test_done;
  end
  // Main sequence
  initial
  begin
    rn = $urandom(32'hDC57);
    tick(20);
    resetn_i <= 1'b1;
    tick(3);
    bus(0, 8'h00, 0);
    check(rd, 32'h10);
    bus(0, 8'h04, 0);
    check(rd, 32'hC0);
    bus(1, 8'h0C, 32'hFFFFFFFF);
    bus(0, 8'h0C, 0);
    check(rd, 0);
    // Lane 1 only: spare byte taken, selectors and unmapped write leave no trace
    sl <= 4'h2;
    bus(1, 8'h00, 32'hABFF);
    sl <= 4'hF;
    bus(0, 8'h00, 0);
    check(rd, 32'hAB10);
    // Switching off first; only then is the pair state writable
    bus(1, 8'h04, 0);
    bus(1, 8'h04, 32'h20);
    bus(0, 8'h04, 0);
    check(rd, 32'h20);
    check(px, 1);
    plug <= 1;
    for (k = 0; k < 16; k = k + 1)
    begin
      bus(1, 8'h00, {24'h0, k[3:0], k[3:0]});
      {rx, tx, co} <= 0;
      tick(BL + 4);
      rn = $urandom;
      {want, sp, fd, co} <= rn[3:0];
      rx <= rn[4] & (k != 8);
      tx <= rn[5] & (k != 8);
      tick(8);
      check(led, {2{exp_led(k[3:0])}});
    end
    {rx, tx, co} <= 0;
    want <= 1;
    bus(1, 8'h00, 32'h11);
    tick(BL + 6);
    tx <= 1;
    tick(1);
    tx <= 0;
    tick(BL - 2);
    check(led, 3);
    tick(6);
    check(led, 0);
    bus(1, 8'h00, 32'h88);
    tx <= 1;
    n = 0;
    for (i = 0; i < 4 * BL; i = i + 1)
    begin
      tick(1);
      n = n + (led != 2'h3);
    end
    check(n > 0 && n < 4 * BL, 1);
    tx <= 0;
    bus(1, 8'h04, 32'hC0);
    tick(5);
    bus(0, 8'h04, 0);
    check(rd, 32'hF0);
    la <= 0;
    pa <= 1;
    bus(1, 8'h04, 32'h60);
    tick(10);
    check(done, 0);
    bus(1, 8'h04, 32'hE0);
    tick(10);
    check(done, 1);
    la <= 1;
    pa <= 0;
    for (i = 0; i < 2; i = i + 1)
    begin
      sd = i ? $urandom_range(15, 1) : 4'h0;
      plug <= 0;
      bus(1, 8'h04, 0);
      bus(1, 8'h04, {24'h0, 4'h4, sd});
      if (sd == 4'h0)
        sd = 4'h5;
      for (k = 4; k < 10; k = k + 1)
      begin
        n = 0;
        rd = 0;
        while (rd[11:8] != k && n < 200)
        begin
          bus(0, 8'h08, 0);
          n = n + 1;
        end
        check(rd[11:8], k);
        if (k < 6 || k > 7)
          check(px, sd[k < 6 ? k - 4 : k - 6]);
      end
      want <= px;
      plug <= 1;
      tick(12);
      check(done, 1);
    end
    test_done;
  end
endmodule
